/* hw/snbm_pkg.sv */
// constants and types of the nine-bit multiprocessor serial port
package snbm_pkg;
  localparam logic [7:0] SNBM_A_PWR = 8'h87;
  localparam logic [7:0] SNBM_A_SCTL = 8'h98;
  localparam logic [7:0] SNBM_A_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] SNBM_A_SLAVE_ADDRESS = 8'hA9;
  localparam logic [7:0] SNBM_A_SMASK = 8'hB9;
  localparam int SNBM_B_MSHI = 7;
  localparam int SNBM_B_MSLO = 6;
  localparam int SNBM_B_MPEN = 5;
  localparam int SNBM_B_REN = 4;
  localparam int SNBM_B_TX9 = 3;
  localparam int SNBM_B_RX9 = 2;
  localparam int SNBM_B_TXD = 1;
  localparam int SNBM_B_RXD = 0;
  localparam int SNBM_B_BAUD2 = 7;
  localparam int SNBM_B_FEVIEW = 6;
  localparam logic [7:0] SNBM_RST_BYTE = 8'h00;
  localparam logic [3:0] SNBM_BITS_M1 = 4'hA;
  localparam logic [3:0] SNBM_BITS_M23 = 4'hB;
  localparam logic [3:0] SNBM_SLICE_LAST = 4'hF;
  localparam logic [3:0] SNBM_SMP_A = 4'h7;
  localparam logic [3:0] SNBM_SMP_C = 4'h9;
  localparam logic [3:0] SNBM_M0_LAST_FAST = 4'h3;
  localparam logic [3:0] SNBM_M0_LAST_SLOW = 4'hB;
  localparam logic [3:0] SNBM_M0_LO_FAST = 4'h1;
  localparam logic [3:0] SNBM_M0_LO_SLOW = 4'h3;
  localparam logic [3:0] SNBM_M0_HI_FAST = 4'h3;
  localparam logic [3:0] SNBM_M0_HI_SLOW = 4'h9;
  localparam logic [2:0] SNBM_M0_BITS_LAST = 3'h7;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } snbm_sfr_req_t;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SEND = 3'b010, TX_M0 = 3'b100} snbm_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} snbm_rx_st_t;
endpackage

/* hw/snbm_uart.sv */
// nine-bit multiprocessor serial port with address recognition
// How it works
// RULE_01: mode 2 frame: start, 8 data, ninth, stop
// RULE_02: mode 2 rate is clock over 32/64
// RULE_03: tx bits launch at counter rollovers
// RULE_04: done flag set at eleventh rollover
// RULE_05: receive only while receive enable set
// RULE_06: falling edge resets the receive slice counter
// RULE_07: bit is majority of slices 7-9
// RULE_08: nonzero start bit aborts reception
// RULE_09: load buffer only if flag clear, qualified
// RULE_10: after mid stop, watch for edge again
// RULE_11: mode 3 is mode 2 at timer rate
// RULE_12: mode pair selects four frame types
// RULE_13: any buffer write starts transmission
// RULE_14: mode 0 receive starts on enable, flag clear
// RULE_15: framing error sticky until software clears
// RULE_16: bit 7 shows error or mode bit
// RULE_17: software selects error view when accessing
// RULE_18: given address compares masked bits only
// RULE_19: broadcast is address OR mask, zeros ignored
// RULE_20: multiproc frames need qualifier and address match
// RULE_21: addresses carry ninth bit; slaves toggle enable
// RULE_22: address and mask reset to zero
// RULE_23: buffer write to tx, read from rx
// RULE_24: timer modes use overflow over 16/32
// RULE_25: mode 0 rate clock over 12 or 4
// RULE_26: baud select high divides by 32
// RULE_27: done flags sticky, request interrupt
`timescale 1ns/10ps
`default_nettype none
module snbm_uart
  import snbm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire snbm_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic t1_ovf,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe,
  output logic txd_o,
  output logic irq
);
  logic sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q, baud_double_select_q, frame_error_view_select_q;
  logic [7:0] slave_address_q, slave_address_mask_q, rbuf_q, rdata_q;
  logic [1:0] pre_q;
  logic t1h_q;
  logic [3:0] tx16_q, rx16_q, txn_q, rxn_q, ph_q;
  logic [2:0] rs_q, m0n_q;
  logic rxf_q, rxprev_q, dir_q, txd_q, rxo_q, rxoe_q, irq_q;
  logic [1:0] samp_q;
  logic [10:0] txsr_q;
  logic [8:0] rxsr_q;
  snbm_tx_st_t tx_st_q;
  snbm_rx_st_t rx_st_q;

  wire wr_sctl = ce & sfr_req.wr & (sfr_req.addr == SNBM_A_SCTL);
  wire wr_serial_buffer = ce & sfr_req.wr & (sfr_req.addr == SNBM_A_SERIAL_BUFFER);
  wire wr_pwr = ce & sfr_req.wr & (sfr_req.addr == SNBM_A_PWR);
  wire wr_sadr = ce & sfr_req.wr & (sfr_req.addr == SNBM_A_SLAVE_ADDRESS);
  wire wr_smsk = ce & sfr_req.wr & (sfr_req.addr == SNBM_A_SMASK);
  wire [7:0] wd = sfr_req.wdata;
  wire [1:0] mode = {sm0_q, sm1_q}; // RULE_12
  wire m0 = (mode == 2'b00);
  wire [3:0] nbits = sm0_q ? SNBM_BITS_M23 : SNBM_BITS_M1; // RULE_12
  // mode 2: 16x tick every 2 or 4 clocks; timer modes: overflow, halved unless doubled
  wire tick = ce & ((mode == 2'b10) ? (baud_double_select_q ? pre_q[0] : (&pre_q)) // RULE_02 RULE_26
                                    : (t1_ovf & (baud_double_select_q | t1h_q))); // RULE_11 RULE_24
  wire tx_roll = tick & (tx16_q == SNBM_SLICE_LAST);
  wire fall = tick & rxprev_q & ~rxf_q;
  wire busy = (rx_st_q == RX_BUSY);
  wire vote = (samp_q[1] & samp_q[0]) | (samp_q[1] & rxf_q) | (samp_q[0] & rxf_q); // RULE_07
  wire decide = busy & tick & (rx16_q == SNBM_SMP_C);
  wire rx_fin = decide & (rxn_q == nbits - 4'h1) & ren_q & ~m0;
  wire [7:0] rx_byte = sm0_q ? rxsr_q[7:0] : rxsr_q[8:1];
  wire rx_qual = sm0_q ? rxsr_q[8] : vote; // RULE_20
  wire given_hit = (((rx_byte ^ slave_address_q) & slave_address_mask_q) == 8'h00); // RULE_18
  wire [7:0] bcast = slave_address_q | slave_address_mask_q; // RULE_19
  wire bcast_hit = ((rx_byte & bcast) == bcast); // RULE_19
  wire accept = ~ri_q & (~sm2_q | (rx_qual & (given_hit | bcast_hit))); // RULE_09 RULE_20 RULE_21
  wire [3:0] m0_last = sm2_q ? SNBM_M0_LAST_FAST : SNBM_M0_LAST_SLOW; // RULE_25
  wire [3:0] m0_lo = sm2_q ? SNBM_M0_LO_FAST : SNBM_M0_LO_SLOW;
  wire [3:0] m0_hi = sm2_q ? SNBM_M0_HI_FAST : SNBM_M0_HI_SLOW;
  wire in_m0 = (tx_st_q == TX_M0);
  wire m0_end = in_m0 & (ph_q == m0_last) & (m0n_q == SNBM_M0_BITS_LAST);
  // fast rate samples the last bit on the closing phase, so take it straight from the pin
  wire [7:0] m0_rx_byte = (m0_hi == m0_last) ? {rxf_q, txsr_q[7:1]} : txsr_q[7:0];
  wire tx_done = (tx_st_q == TX_SEND) & tx_roll & (txn_q == nbits - 4'h1); // RULE_04
  wire ti_set = tx_done | (m0_end & ~dir_q);
  wire ri_set = (rx_fin & accept) | (m0_end & dir_q);
  wire fe_set = rx_fin & ~vote; // RULE_15
  wire m0_rx_go = m0 & ren_q & ~ri_q & (tx_st_q == TX_IDLE); // RULE_14
  wire [7:0] sctl_rd = {frame_error_view_select_q ? fe_q : sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q}; // RULE_16
  wire [7:0] rd_mux = (sfr_req.addr == SNBM_A_SCTL) ? sctl_rd :
                      (sfr_req.addr == SNBM_A_SERIAL_BUFFER) ? rbuf_q : // RULE_23
                      (sfr_req.addr == SNBM_A_PWR) ? {baud_double_select_q, frame_error_view_select_q, 6'h00} :
                      (sfr_req.addr == SNBM_A_SLAVE_ADDRESS) ? slave_address_q :
                      (sfr_req.addr == SNBM_A_SMASK) ? slave_address_mask_q : 8'h00;

  // control and status bits; hardware sets win over a same-cycle software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      {sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q, baud_double_select_q, frame_error_view_select_q} <= 11'h000;
      slave_address_q <= SNBM_RST_BYTE; // RULE_22
      slave_address_mask_q <= SNBM_RST_BYTE; // RULE_22
      rbuf_q <= SNBM_RST_BYTE;
    end else if (ce) begin
      if (wr_sctl) begin
        if (frame_error_view_select_q) begin
          fe_q <= wd[SNBM_B_MSHI] | fe_set; // RULE_16 RULE_17
        end else begin
          sm0_q <= wd[SNBM_B_MSHI]; // RULE_16
          fe_q <= fe_q | fe_set;
        end
        sm1_q <= wd[SNBM_B_MSLO];
        sm2_q <= wd[SNBM_B_MPEN];
        ren_q <= wd[SNBM_B_REN];
        tb8_q <= wd[SNBM_B_TX9];
        rb8_q <= (rx_fin & accept) ? rx_qual : wd[SNBM_B_RX9];
        ti_q <= wd[SNBM_B_TXD] | ti_set; // RULE_27
        ri_q <= wd[SNBM_B_RXD] | ri_set; // RULE_27
      end else begin
        fe_q <= fe_q | fe_set; // RULE_15
        ti_q <= ti_q | ti_set; // RULE_27
        ri_q <= ri_q | ri_set; // RULE_27
        if (rx_fin & accept) begin
          rb8_q <= rx_qual; // RULE_01 RULE_09
        end
      end
      if (rx_fin & accept) begin
        rbuf_q <= rx_byte; // RULE_09 RULE_23
      end else if (m0_end & dir_q) begin
        rbuf_q <= m0_rx_byte; // RULE_14
      end
      if (wr_pwr) begin
        baud_double_select_q <= wd[SNBM_B_BAUD2];
        frame_error_view_select_q <= wd[SNBM_B_FEVIEW];
      end
      if (wr_sadr) begin
        slave_address_q <= wd;
      end
      if (wr_smsk) begin
        slave_address_mask_q <= wd;
      end
    end
  end

  // baud prescalers and free-running transmit slice counter
  always_ff @(posedge clk) begin
    if (srst) begin
      pre_q <= 2'h0;
      t1h_q <= 1'b0;
      tx16_q <= 4'h0;
    end else if (ce) begin
      pre_q <= pre_q + 2'h1;
      if (t1_ovf) begin
        t1h_q <= ~t1h_q;
      end
      if (tick) begin
        tx16_q <= tx16_q + 4'h1; // RULE_03
      end
    end
  end

  // pin synchroniser: level changes only once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      rs_q <= 3'h7;
      rxf_q <= 1'b1;
      rxprev_q <= 1'b1;
    end else if (ce) begin
      rs_q <= {rs_q[1:0], rxd_i};
      if (rs_q[1] == rs_q[2]) begin
        rxf_q <= rs_q[2];
      end
      if (tick) begin
        rxprev_q <= rxf_q; // RULE_06
      end
    end
  end

  // asynchronous receiver
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_st_q <= RX_IDLE;
      rx16_q <= 4'h0;
      rxn_q <= 4'h0;
      samp_q <= 2'h0;
      rxsr_q <= 9'h000;
    end else if (ce) begin
      case (rx_st_q)
        RX_IDLE: begin
          if (~m0 & ren_q & fall) begin // RULE_05 RULE_10
            rx_st_q <= RX_BUSY;
            rx16_q <= 4'h0; // RULE_06
            rxn_q <= 4'h0;
          end
        end
        RX_BUSY: begin
          if (~ren_q | m0) begin
            rx_st_q <= RX_IDLE; // RULE_05
          end else if (tick) begin
            rx16_q <= rx16_q + 4'h1;
            if ((rx16_q >= SNBM_SMP_A) && (rx16_q < SNBM_SMP_C)) begin
              samp_q <= {samp_q[0], rxf_q}; // RULE_07
            end
            if (decide) begin
              if ((rxn_q == 4'h0) && vote) begin
                rx_st_q <= RX_IDLE; // RULE_08
              end else if (rxn_q == nbits - 4'h1) begin
                rx_st_q <= RX_IDLE; // RULE_10
              end else begin
                if (rxn_q != 4'h0) begin
                  rxsr_q <= {vote, rxsr_q[8:1]}; // RULE_01
                end
                rxn_q <= rxn_q + 4'h1;
              end
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // transmitter and mode 0 shift engine; a new buffer write restarts it
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_st_q <= TX_IDLE;
      txsr_q <= 11'h7FF;
      txn_q <= 4'h0;
      ph_q <= 4'h0;
      m0n_q <= 3'h0;
      dir_q <= 1'b0;
      txd_q <= 1'b1;
      rxo_q <= 1'b1;
      rxoe_q <= 1'b0;
    end else if (ce) begin
      if (wr_serial_buffer) begin // RULE_13
        // mode 0 has no start bit: data goes out from bit 0
        txsr_q <= m0 ? {3'b111, wd} : {1'b1, sm0_q ? tb8_q : 1'b1, wd, 1'b0}; // RULE_01
        txn_q <= 4'h0;
        ph_q <= 4'h0;
        m0n_q <= 3'h0;
        dir_q <= 1'b0;
        tx_st_q <= m0 ? TX_M0 : TX_SEND;
      end else if (m0_rx_go & ~ri_set) begin
        ph_q <= 4'h0;
        m0n_q <= 3'h0;
        dir_q <= 1'b1;
        rxoe_q <= 1'b0;
        tx_st_q <= TX_M0; // RULE_14
      end else begin
        case (tx_st_q)
          TX_IDLE: begin
            txd_q <= 1'b1;
            rxoe_q <= 1'b0;
          end
          TX_SEND: begin
            if (tx_roll) begin // RULE_03
              txd_q <= txsr_q[0];
              txsr_q <= {1'b1, txsr_q[10:1]};
              txn_q <= txn_q + 4'h1;
              if (txn_q == nbits - 4'h1) begin
                tx_st_q <= TX_IDLE; // RULE_04
              end
            end
          end
          TX_M0: begin
            // shift clock low in the middle half of each bit
            txd_q <= ~((ph_q >= m0_lo) && (ph_q < m0_hi)); // RULE_25
            ph_q <= (ph_q == m0_last) ? 4'h0 : ph_q + 4'h1;
            if ((ph_q == 4'h0) && ~dir_q) begin
              rxo_q <= txsr_q[0];
              rxoe_q <= 1'b1;
              txsr_q <= {1'b1, txsr_q[10:1]};
            end
            if ((ph_q == m0_hi) && dir_q) begin
              txsr_q[7:0] <= {rxf_q, txsr_q[7:1]}; // RULE_14
            end
            if (ph_q == m0_last) begin
              m0n_q <= m0n_q + 3'h1;
              if (m0n_q == SNBM_M0_BITS_LAST) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else if (ce) begin
      if (sfr_req.rd) begin
        rdata_q <= rd_mux;
      end
      irq_q <= ti_q | ri_q; // RULE_27
    end
  end

  assign sfr_rdata = rdata_q;
  assign txd_o = txd_q;
  assign rxd_o = rxo_q;
  assign rxd_oe = rxoe_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

/* sim/snbm_uart_chk.sv */
// assertion checker for the nine-bit serial port
`timescale 1ns/10ps
`default_nettype none
module snbm_uart_chk
  import snbm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire snbm_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic t1_ovf,
  input wire logic rxd_i,
  input wire logic rxd_o,
  input wire logic rxd_oe,
  input wire logic txd_o,
  input wire logic irq
);
  logic [4:0] sh_q;
  logic [4:0] gap_q;
  logic t_q;
  logic arm_q;
  wire wr_ok = ce && sfr_req.wr;
  wire w_ctl = wr_ok && sfr_req.addr == SNBM_A_SCTL;
  wire w_pwr = wr_ok && sfr_req.addr == SNBM_A_PWR;
  wire w_buf = wr_ok && sfr_req.addr == SNBM_A_SERIAL_BUFFER;
  wire [1:0] md = sh_q[4:3];
  wire m2 = md == 2'b10 && sh_q[0];
  wire chg = txd_o != t_q;
  // shadow of mode, multiproc, error view, rate
  always_ff @(posedge clk) begin
    if (srst) begin
      sh_q <= 5'h00;
    end else if (w_ctl) begin
      sh_q <= {sh_q[1] ? sh_q[4] : sfr_req.wdata[7], sfr_req.wdata[6:5], sh_q[1:0]};
    end else if (w_pwr) begin
      sh_q <= {sh_q[4:2], sfr_req.wdata[6], sfr_req.wdata[7]};
    end
  end
  // edge spacing only meaningful once a first edge armed it
  always_ff @(posedge clk) begin
    t_q <= txd_o;
    gap_q <= chg ? 5'h00 : gap_q + 5'h01;
    arm_q <= !srst && m2 && (arm_q || chg);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst; $fell(srst) |-> sfr_rdata == 8'h00 && txd_o && !irq && !rxd_oe; endproperty
  property p_rd; !(ce && sfr_req.rd) |=> $stable(sfr_rdata); endproperty
  property p_grid; m2 && arm_q && chg |-> gap_q == 5'h1F; endproperty
  property p_start; w_buf && m2 && txd_o |-> ##[1:40] !txd_o; endproperty
  property p_done; w_buf && m2 && !irq |-> ##[300:360] irq; endproperty
  property p_irqf; $fell(irq) |-> $past(w_ctl, 2); endproperty
  property p_oe; rxd_oe |-> md == 2'b00; endproperty
  property p_m0s; $fell(txd_o) && md == 2'b00 && !sh_q[2] |-> !txd_o [*6] ##1 txd_o; endproperty
  property p_m0f; $fell(txd_o) && md == 2'b00 && sh_q[2] |-> !txd_o [*2] ##1 txd_o; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_rd: assert property (p_rd) else $error("read data moved");
  a_grid: assert property (p_grid) else $error("bit edge off grid");
  a_start: assert property (p_start) else $error("no start bit");
  a_done: assert property (p_done) else $error("tx done late");
  a_irqf: assert property (p_irqf) else $error("flag cleared alone");
  a_oe: assert property (p_oe) else $error("data drive outside mode 0");
  a_m0s: assert property (p_m0s) else $error("slow shift clock");
  a_m0f: assert property (p_m0f) else $error("fast shift clock");
  c_m2: cover property (m2 && chg);
  c_irq: cover property ($rose(irq));
  c_m0: cover property ($fell(txd_o) && md == 2'b00);
endmodule
bind snbm_uart snbm_uart_chk u_chk (.clk(clk), .srst(srst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .t1_ovf(t1_ovf), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o), .irq(irq));
`default_nettype wire

/* sim/snbm_node.sv */
// remote serial node: sends and captures frames
`timescale 1ns/10ps
`default_nettype none
module snbm_node (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bc = 32;
  logic [10:0] cap;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] d, input logic n, input logic st);
    logic [10:0] f;
    f = {st, n, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      repeat (bc) @(posedge clk);
      #1;
    end
    rxd = 1'b1;
    repeat (bc) @(posedge clk);
    #1;
  endtask
  // too short to survive the mid-bit vote
  task automatic glitch();
    rxd = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rxd = 1'b1;
  endtask
  always begin
    @(negedge txd);
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      cap[i] = txd;
      repeat (bc) @(posedge clk);
    end
  end
endmodule
`default_nettype wire

/* sim/snbm_uart_tb_top.sv */
// self-checking bench for the nine-bit serial port
`timescale 1ns/10ps
`default_nettype none
module snbm_uart_tb_top;
  import snbm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic t1_ovf = 1'b0;
  snbm_sfr_req_t req = '0;
  logic [7:0] rdata, q, d, am, mk, ctl, m0cap;
  logic rxd_o, rxd_oe, txd, nrxd, t9, irq_w;
  int seed = 32'hB52AB6A5;
  int n_errors = 0;
  int total_checks = 0;
  int ph = 0;
  wire rxd_w = rxd_oe ? rxd_o : nrxd;
  always #25 clk = ~clk;
  // overflow every third clock: 48-clock bits
  always @(posedge clk) begin
    #1;
    ph = (ph + 1) % 3;
    t1_ovf = ph == 0;
  end
  snbm_uart uut (.clk(clk), .srst(srst), .ce(1'b1), .sfr_req(req), .sfr_rdata(rdata), .t1_ovf(t1_ovf),
    .rxd_i(rxd_w), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd), .irq(irq_w));
  snbm_node node (.clk(clk), .txd(txd), .rxd(nrxd));
  // mode 0 data is valid at the rising shift clock
  always @(posedge txd) begin
    if (rxd_oe === 1'b1) begin
      m0cap = {rxd_o, m0cap[7:1]};
    end
  end
  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    req = '{addr: a, wr: w, rd: !w, wdata: v};
    @(posedge clk);
    #1;
    req = '0;
    q = rdata;
  endtask
  function automatic logic hit(input logic [7:0] b);
    return ((b ^ am) & mk) == 8'h00 || (b & (am | mk)) == (am | mk);
  endfunction
  task automatic rx(input logic [7:0] b, input logic n, input logic e);
    node.send(b, n, 1'b1);
    bus(1'b0, SNBM_A_SCTL, 8'h00);
    chk(q & 8'h01, {7'h00, e});
    if (e) begin
      chk(q & 8'h04, {5'h00, n, 2'h0});
      bus(1'b0, SNBM_A_SERIAL_BUFFER, 8'h00);
      chk(q, b);
      bus(1'b1, SNBM_A_SCTL, ctl);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    bus(1'b0, SNBM_A_SLAVE_ADDRESS, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, SNBM_A_SMASK, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, 8'h55, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, SNBM_A_PWR, 8'h80);
    for (int k = 0; k < 3; k++) begin
      d = 8'($random(seed));
      t9 = d[7];
      node.bc = k ? 48 : 32;
      ctl = {k != 2, k != 0, 2'b01, t9, 3'b000};
      bus(1'b1, SNBM_A_SCTL, ctl);
      node.cap = 'x;
      bus(1'b1, SNBM_A_SERIAL_BUFFER, d);
      repeat (node.bc * 13) @(posedge clk);
      chk(node.cap[8:1], d);
      chk({5'h00, node.cap[10:9], node.cap[0]}, {5'h00, 1'b1, t9 | (k == 2), 1'b0});
      bus(1'b0, SNBM_A_SCTL, 8'h00);
      chk(q & 8'h02, 8'h02);
      chk({7'h00, irq_w}, 8'h01);
    end
    am = 8'($random(seed));
    mk = 8'($random(seed));
    bus(1'b1, SNBM_A_SLAVE_ADDRESS, am);
    bus(1'b1, SNBM_A_SMASK, mk);
    bus(1'b0, SNBM_A_SLAVE_ADDRESS, 8'h00);
    chk(q, am);
    node.bc = 32;
    ctl = 8'h90;
    bus(1'b1, SNBM_A_SCTL, ctl);
    d = 8'($random(seed));
    rx(d, d[7], 1'b1);
    ctl = 8'hB0;
    bus(1'b1, SNBM_A_SCTL, ctl);
    for (int k = 0; k < 6; k++) begin
      d = k == 0 ? am : k == 1 ? 8'hFF : 8'($random(seed));
      rx(d, k != 2, hit(d) && k != 2);
    end
    ctl = 8'h90;
    bus(1'b1, SNBM_A_SCTL, ctl);
    node.send(d, 1'b0, 1'b1);
    node.send(~d, 1'b0, 1'b1);
    bus(1'b0, SNBM_A_SERIAL_BUFFER, 8'h00);
    chk(q, d);
    bus(1'b1, SNBM_A_PWR, 8'hC0);
    node.send(d, 1'b0, 1'b0);
    bus(1'b0, SNBM_A_SCTL, 8'h00);
    chk(q & 8'h80, 8'h80);
    bus(1'b1, SNBM_A_PWR, 8'h80);
    bus(1'b1, SNBM_A_SCTL, ctl);
    rx(d, 1'b0, 1'b1);
    bus(1'b1, SNBM_A_PWR, 8'hC0);
    bus(1'b0, SNBM_A_SCTL, 8'h00);
    chk(q & 8'h80, 8'h80);
    bus(1'b1, SNBM_A_SCTL, 8'h10);
    bus(1'b0, SNBM_A_SCTL, 8'h00);
    chk(q & 8'h80, 8'h00);
    bus(1'b1, SNBM_A_PWR, 8'h80);
    bus(1'b0, SNBM_A_SCTL, 8'h00);
    chk(q & 8'h80, 8'h80);
    ctl = 8'h80;
    bus(1'b1, SNBM_A_SCTL, ctl);
    rx(d, 1'b0, 1'b0);
    ctl = 8'h90;
    bus(1'b1, SNBM_A_SCTL, ctl);
    node.glitch();
    repeat (400) @(posedge clk);
    bus(1'b0, SNBM_A_SCTL, 8'h00);
    chk(q & 8'h01, 8'h00);
    rx(d, 1'b1, 1'b1);
    ctl = 8'hD0;
    bus(1'b1, SNBM_A_SCTL, ctl);
    node.bc = 48;
    d = 8'($random(seed));
    rx(d, d[0], 1'b1);
    for (int k = 0; k < 2; k++) begin
      ctl = k ? 8'h20 : 8'h00;
      bus(1'b1, SNBM_A_SCTL, ctl);
      bus(1'b1, SNBM_A_SERIAL_BUFFER, d);
      repeat (140) @(posedge clk);
      bus(1'b0, SNBM_A_SCTL, 8'h00);
      chk(q & 8'h02, 8'h02);
      chk(m0cap, d);
    end
    // far side holds the data line low so every shifted-in bit is zero
    node.rxd = 1'b0;
    bus(1'b1, SNBM_A_SCTL, 8'h30);
    repeat (60) @(posedge clk);
    bus(1'b0, SNBM_A_SCTL, 8'h00);
    chk(q & 8'h01, 8'h01);
    bus(1'b0, SNBM_A_SERIAL_BUFFER, 8'h00);
    chk(q, 8'h00);
    end_sim();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
